//--- logic/mtc_pkg.sv
// Constants, codes and carrier types for the magtape transport controller
package mtc_pkg;

  // ==========================================================
  // Instruction codes (octal group 670X and neighbours)
  localparam logic [8:0] IOT_GROUP = 9'h1B8;
  localparam logic [11:0] IOT_LOAD_WC = 12'hDC1;
  localparam logic [11:0] IOT_CLR_CA = 12'hDC2;
  localparam logic [11:0] IOT_LOAD_CA = 12'hDC3;
  localparam logic [11:0] IOT_SET_BRK = 12'hDC4;
  localparam logic [11:0] IOT_LOAD_DBUF = 12'hDC7;
  localparam logic [11:0] IOT_CLR_XPORT = 12'hDC9;
  localparam logic [11:0] IOT_INIT = 12'hDD4;
  localparam logic [11:0] IOT_CLR_FLAGS = 12'hDD5;

  // ==========================================================
  // Register map (byte offsets) and function register fields
  localparam logic [3:0] REG_FUNC = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ADDR = 4'h8;
  localparam logic [3:0] REG_WCOUNT = 4'hC;
  localparam int FUNC_FN_LSB = 0;
  localparam int FUNC_CDUMP_BIT = 3;
  localparam int FUNC_GO_BIT = 5;
  localparam int FUNC_SEL_LSB = 6;
  localparam logic [2:0] FUNC_RESET = 3'h0;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 20;
  localparam int PRESET_NS = 2500;
  localparam int PRESET_CYC = PRESET_NS / CLK_NS;
  localparam int PRESET_W = $clog2(PRESET_CYC + 1);

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    FN_OFFLINE = 3'b000,
    FN_REWIND = 3'b001,
    FN_READ = 3'b010,
    FN_RDCMP = 3'b011,
    FN_WRITE = 3'b100,
    FN_WRITE_FILE_MARK_CMD = 3'b101,
    FN_SPFWD = 3'b110,
    FN_SPREV = 3'b111
  } mtc_fn_t;

  typedef struct packed {
    logic selected_online_status;
    logic transport_ready;
    logic tape_start_marker;
    logic rewinding_status;
    logic settling_down_status;
    logic vertical_parity_error;
    logic cyclic_check_error;
    logic longitudinal_check_error;
    logic cyclic_check_strobe;
    logic longitudinal_check_strobe;
  } mtc_status_t;

  typedef struct packed {
    logic forward_motion_cmd;
    logic reverse_motion_cmd;
    logic rewind_cmd;
    logic write_file_mark_cmd;
    logic write_enable_line;
    logic write_data_ready;
    logic set_pulse;
    logic tape_init;
    logic transport_init;
    logic [2:0] buffered_select;
    logic [7:0] write_data_bit;
  } mtc_cmd_t;

  // Status register layout, bit 0 at the right
  typedef struct packed {
    logic [14:0] zero;
    logic busy;
    logic job_done;
    logic error;
    logic parity_err;
    logic compare_err;
    logic unit_change;
    logic active;
    mtc_status_t tape;
  } mtc_stat_word_t;

endpackage

//--- logic/mtc_transport_control.sv
// Tape controller core: instruction decode, data break, commands, status
`timescale 1ns/1ns
module mtc_transport_control
  import mtc_pkg::*;
#(
  parameter int WORD_W = 12
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic iot_strobe,
  input wire logic [11:0] iot_code,
  input wire logic [WORD_W-1:0] acc_bus,
  output logic accumulator_input_gate,
  input wire logic proc_init,
  input wire logic fourth_time_pulse,
  output logic break_request,
  input wire logic break_grant,
  input wire logic [WORD_W-1:0] mem_data,
  output logic [WORD_W-1:0] address_counter,
  input wire logic [2:0] unit_select,
  input wire mtc_status_t tape_status,
  output mtc_cmd_t tape_cmd,
  output logic unit_change_flag,
  output logic controller_busy,
  output logic job_done_flag
);

  // ==========================================================
  // Elaboration check: write data needs eight bits
  if (WORD_W < 8) begin : g_width_chk
    $error("WORD_W must be at least 8");
  end

  // ==========================================================
  // Transport status synchroniser and validity gate
  mtc_status_t st_meta_q, st_sync_q, stv;
  logic rdy_prev_q;
  // Two flops; only the second is looked at
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_meta_q <= '0;
      st_sync_q <= '0;
      rdy_prev_q <= 1'b0;
    end else if (clk_en) begin
      st_meta_q <= tape_status;
      st_sync_q <= st_meta_q;
      rdy_prev_q <= stv.transport_ready;
    end
  end
  // Nothing else is trusted until the unit says selected and online
  always_comb begin
    stv = st_sync_q.selected_online_status ? st_sync_q : '0;
  end

  // ==========================================================
  // Instruction decode, edge-qualified to one cycle
  logic iot_prev_q, iot_s, grp;
  logic i_load_wc, i_clr_ca, i_load_ca, i_set_break_request_instr, i_ldbr, i_clt, i_init, clf_s;
  logic mclr, status_clear;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      iot_prev_q <= 1'b0;
    end else if (clk_en) begin
      iot_prev_q <= iot_strobe;
    end
  end
  // A held strobe still acts once
  assign iot_s = iot_strobe && !iot_prev_q && clk_en;
  assign grp = iot_s && (iot_code[11:3] == IOT_GROUP);
  assign accumulator_input_gate = grp;
  assign i_load_wc = grp && iot_code == IOT_LOAD_WC;
  assign i_clr_ca = grp && iot_code == IOT_CLR_CA;
  assign i_load_ca = grp && iot_code == IOT_LOAD_CA;
  assign i_set_break_request_instr = grp && iot_code == IOT_SET_BRK;
  assign i_ldbr = grp && iot_code == IOT_LOAD_DBUF;
  assign i_clt = iot_s && iot_code == IOT_CLR_XPORT;
  assign i_init = iot_s && iot_code == IOT_INIT;
  assign clf_s = iot_s && iot_code == IOT_CLR_FLAGS;
  // Master clear sources; clear-flags splits on transport ready
  assign mclr = proc_init || (clf_s && stv.transport_ready) || i_clt || i_init;
  assign status_clear = clf_s && !stv.transport_ready;

  // ==========================================================
  // Function register and operation sequencing
  mtc_fn_t fn_q;
  logic cdump_q, go_q, op_q, set_q, preset_q, busy_q, job_q, wdr_q;
  logic [2:0] bsel_q;
  logic [PRESET_W-1:0] pcnt_q;
  logic func_wr, go_fire, data_op, grant, wc_ovf, spr_bot, ready_rise, job_set, sel_err;
  logic [WORD_W-1:0] ca_q, wc_q, dbuf_q;

  assign func_wr = avs_write && !avs_waitrequest && clk_en && avs_address == REG_FUNC;
  assign go_fire = func_wr && avs_writedata[FUNC_GO_BIT] && stv.transport_ready && !op_q;
  assign data_op = op_q && (fn_q == FN_READ || fn_q == FN_RDCMP || fn_q == FN_WRITE);
  assign grant = break_grant && break_request && clk_en;
  assign wc_ovf = grant && data_op && (wc_q == {WORD_W{1'b1}});
  assign spr_bot = op_q && fn_q == FN_SPREV && stv.tape_start_marker;
  assign ready_rise = stv.transport_ready && !rdy_prev_q && clk_en;
  // Non-data functions end when the unit comes ready again
  assign job_set = i_ldbr || wc_ovf || (op_q && !data_op && ready_rise) || (spr_bot && clk_en);
  assign sel_err = set_q && !stv.selected_online_status;
  // Function fields are locked while an operation runs
  always_ff @(posedge mclk) begin
    if (sys_rst || (mclr && clk_en)) begin
      fn_q <= mtc_fn_t'(FUNC_RESET);
      cdump_q <= 1'b0;
      go_q <= 1'b0;
      bsel_q <= '0;
    end else if (func_wr && !op_q) begin
      fn_q <= mtc_fn_t'(avs_writedata[FUNC_FN_LSB+:3]);
      cdump_q <= avs_writedata[FUNC_CDUMP_BIT];
      go_q <= avs_writedata[FUNC_GO_BIT];
      bsel_q <= avs_writedata[FUNC_SEL_LSB+:3];
    end else if (clk_en && job_set) begin
      go_q <= 1'b0;
    end
  end
  // Preset timer, then a one-cycle set pulse
  always_ff @(posedge mclk) begin
    if (sys_rst || (mclr && clk_en)) begin
      preset_q <= 1'b0;
      pcnt_q <= '0;
      set_q <= 1'b0;
    end else if (clk_en) begin
      set_q <= 1'b0;
      if (go_fire) begin
        preset_q <= 1'b1;
        pcnt_q <= PRESET_W'(1);
      end else if (preset_q && pcnt_q == PRESET_W'(PRESET_CYC)) begin
        preset_q <= 1'b0;
        set_q <= 1'b1;
      end else if (preset_q) begin
        pcnt_q <= pcnt_q + PRESET_W'(1);
      end
    end
  end
  // Operation in progress from set until job done
  always_ff @(posedge mclk) begin
    if (sys_rst || (mclr && clk_en)) begin
      op_q <= 1'b0;
    end else if (clk_en && job_set) begin
      op_q <= 1'b0;
    end else if (clk_en && set_q) begin
      op_q <= 1'b1;
    end
  end
  // Busy waits for the processor's fourth time pulse
  always_ff @(posedge mclk) begin
    if (sys_rst || (mclr && clk_en)) begin
      busy_q <= 1'b0;
    end else if (clk_en && job_set) begin
      busy_q <= 1'b0;
    end else if (clk_en && go_q && fourth_time_pulse) begin
      busy_q <= 1'b1;
    end
  end
  // Job done; a completing event beats a simultaneous status clear
  always_ff @(posedge mclk) begin
    if (sys_rst || (mclr && clk_en)) begin
      job_q <= 1'b0;
    end else if (clk_en && job_set) begin
      job_q <= 1'b1;
    end else if (status_clear) begin
      job_q <= 1'b0;
    end
  end
  // Write data ready spans the write until the count runs out
  always_ff @(posedge mclk) begin
    if (sys_rst || (mclr && clk_en)) begin
      wdr_q <= 1'b0;
    end else if (wc_ovf) begin
      wdr_q <= 1'b0;
    end else if (clk_en && set_q && fn_q == FN_WRITE) begin
      wdr_q <= 1'b1;
    end
  end

  // ==========================================================
  // Data break, address and word counters, data buffer
  logic brk_q, rc_q, vpe_q, err_q, chg_q, rc_set;
  assign rc_set = grant && op_q && fn_q == FN_RDCMP && mem_data != dbuf_q;
  // Request stays up through data operations; grant takes it down
  always_ff @(posedge mclk) begin
    if (sys_rst || (mclr && clk_en)) begin
      brk_q <= 1'b0;
    end else if (clk_en && (i_set_break_request_instr || (data_op && !job_set && !grant))) begin
      brk_q <= 1'b1;
    end else if (grant) begin
      brk_q <= 1'b0;
    end
  end
  assign break_request = brk_q;
  // Address counter freezes after a compare error, keeping the address one past the bad word
  always_ff @(posedge mclk) begin
    if (sys_rst || (clk_en && (mclr || i_clr_ca))) begin
      ca_q <= '0;
    end else if (i_load_ca) begin
      ca_q <= acc_bus;
    end else if (grant && !rc_q) begin
      ca_q <= ca_q + WORD_W'(1);
    end
  end
  assign address_counter = ca_q;
  // Word count runs up from a negative load to zero
  always_ff @(posedge mclk) begin
    if (sys_rst || (mclr && clk_en)) begin
      wc_q <= '0;
    end else if (i_load_wc) begin
      wc_q <= acc_bus;
    end else if (grant) begin
      wc_q <= wc_q + WORD_W'(1);
    end
  end
  // Buffer takes the accumulator, or memory words during a write
  always_ff @(posedge mclk) begin
    if (sys_rst || (mclr && clk_en)) begin
      dbuf_q <= '0;
    end else if (i_ldbr) begin
      dbuf_q <= acc_bus;
    end else if (grant && fn_q == FN_WRITE) begin
      dbuf_q <= mem_data;
    end
  end

  // ==========================================================
  // Error flags; a setting event beats a simultaneous status clear
  always_ff @(posedge mclk) begin
    if (sys_rst || (mclr && clk_en)) begin
      rc_q <= 1'b0;
      vpe_q <= 1'b0;
      err_q <= 1'b0;
    end else if (clk_en) begin
      if (rc_set) begin
        rc_q <= 1'b1;
      end else if (status_clear) begin
        rc_q <= 1'b0;
      end
      if (stv.vertical_parity_error) begin
        vpe_q <= 1'b1;
      end else if (status_clear) begin
        vpe_q <= 1'b0;
      end
      if (rc_set || sel_err || stv.vertical_parity_error || stv.cyclic_check_error ||
          stv.longitudinal_check_error) begin
        err_q <= 1'b1;
      end else if (status_clear) begin
        err_q <= 1'b0;
      end
    end
  end
  // Unit change: mismatch sets, next set pulse clears, mismatch wins
  always_ff @(posedge mclk) begin
    if (sys_rst || (mclr && clk_en)) begin
      chg_q <= 1'b0;
    end else if (clk_en && bsel_q != unit_select) begin
      chg_q <= 1'b1;
    end else if (clk_en && (set_q || status_clear)) begin
      chg_q <= 1'b0;
    end
  end
  assign unit_change_flag = chg_q;
  assign controller_busy = busy_q;
  assign job_done_flag = job_q;

  // ==========================================================
  // Transport command lines, all from flops
  mtc_cmd_t cmd_d;
  // Function decode; code zero also asserts write enable so the unit goes offline
  always_comb begin
    cmd_d = '0;
    cmd_d.forward_motion_cmd = op_q && (fn_q == FN_READ || fn_q == FN_RDCMP ||
      fn_q == FN_WRITE || fn_q == FN_WRITE_FILE_MARK_CMD || fn_q == FN_SPFWD);
    cmd_d.reverse_motion_cmd = op_q && fn_q == FN_SPREV;
    cmd_d.rewind_cmd = op_q && (fn_q == FN_REWIND || fn_q == FN_OFFLINE);
    cmd_d.write_file_mark_cmd = op_q && fn_q == FN_WRITE_FILE_MARK_CMD;
    cmd_d.write_enable_line = op_q && (fn_q == FN_WRITE || fn_q == FN_WRITE_FILE_MARK_CMD ||
      fn_q == FN_REWIND || fn_q == FN_OFFLINE);
    cmd_d.write_data_ready = wdr_q;
    cmd_d.set_pulse = set_q;
    cmd_d.tape_init = mclr || spr_bot || sel_err;
    cmd_d.transport_init = proc_init;
    cmd_d.buffered_select = bsel_q;
    cmd_d.write_data_bit = dbuf_q[7:0];
    if (cdump_q) begin
      cmd_d.write_data_bit[1:0] = 2'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tape_cmd <= '0;
    end else if (clk_en) begin
      tape_cmd <= cmd_d;
    end
  end

  // ==========================================================
  // Avalon-MM slave: one wait state, then answer
  logic ack_q;
  mtc_stat_word_t stat;

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

  always_comb begin
    stat = '0;
    stat.busy = busy_q;
    stat.job_done = job_q;
    stat.error = err_q;
    stat.parity_err = vpe_q;
    stat.compare_err = rc_q;
    stat.unit_change = chg_q;
    stat.active = op_q;
    stat.tape = stv;
  end
  // Read data is latched in the wait cycle so it stands at the answer edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      avs_readdata <= '0;
    end else if (clk_en) begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      if (avs_read && !ack_q) begin
        unique case (avs_address)
          REG_FUNC: avs_readdata <= 32'({bsel_q, go_q, 1'b0, cdump_q, fn_q});
          REG_STATUS: avs_readdata <= stat;
          REG_ADDR: avs_readdata <= 32'(ca_q);
          REG_WCOUNT: avs_readdata <= 32'(wc_q);
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  ca_clear_a: assert property (i_clr_ca |=> ca_q == '0)
    else $error("address counter not cleared");
  clf_full_a: assert property (clf_s && stv.transport_ready |=> !busy_q && !op_q && !job_q)
    else $error("clear flags with ready left state");
  clf_part_a: assert property (status_clear && !job_set && !mclr |=> !job_q)
    else $error("status clear kept job done");
  mclr_a: assert property (clk_en && i_clt |=> ca_q == '0 && !brk_q && !go_q)
    else $error("clear transport missed registers");
  gate_a: assert property (accumulator_input_gate |-> iot_code[11:3] == IOT_GROUP)
    else $error("accumulator gate outside group");
  brk_set_a: assert property (i_set_break_request_instr && !mclr |=> break_request)
    else $error("break request not set");
  chg_a: assert property (clk_en && !mclr && bsel_q != unit_select |=> unit_change_flag)
    else $error("unit change missed");
  busy_set_a: assert property (clk_en && go_q && fourth_time_pulse && !mclr && !job_set
    |=> controller_busy)
    else $error("busy not set at time pulse");
  busy_clr_a: assert property (clk_en && job_set && !mclr
    |=> !controller_busy && job_done_flag)
    else $error("busy not cleared by job done");
  ca_hold_a: assert property (grant && rc_q && !mclr && !i_clr_ca && !i_load_ca
    |=> $stable(ca_q))
    else $error("address counted after compare error");
  vpe_a: assert property (clk_en && stv.vertical_parity_error && !mclr |=> vpe_q)
    else $error("parity error not latched");
  valid_a: assert property (stv.rewinding_status |-> st_sync_q.selected_online_status)
    else $error("status used while not selected");
  rev_a: assert property (tape_cmd.reverse_motion_cmd |-> $past(fn_q) == FN_SPREV)
    else $error("reverse motion for wrong function");
  tinit_a: assert property (clk_en && mclr |=> tape_cmd.tape_init)
    else $error("tape init missing on clear");
  init_a: assert property (clk_en && proc_init |=> tape_cmd.transport_init)
    else $error("transport init not driven");
  wdr_a: assert property (wc_ovf && !mclr |=> !wdr_q)
    else $error("write data ready held past overflow");
  wre_a: assert property (tape_cmd.write_enable_line
    |-> $past(fn_q) != FN_READ && $past(fn_q) != FN_SPFWD)
    else $error("write enable on non-write function");
  cdump_a: assert property (tape_cmd.write_data_bit[1:0] != 2'h0 |-> !$past(cdump_q))
    else $error("core dump bits not forced");
  preset_a: assert property (pcnt_q <= PRESET_W'(PRESET_CYC))
    else $error("preset ran long");
  set_a: assert property (clk_en && preset_q && pcnt_q == PRESET_W'(PRESET_CYC) && !mclr
    |=> set_q)
    else $error("set pulse missing after preset");
  preset_c: cover property (go_fire ##1 preset_q [*8]);
  ovf_c: cover property (wc_ovf);
  rcerr_c: cover property (rc_set ##1 rc_q);

endmodule // mtc_transport_control

//--- verification/mtc_tape_model.sv
// Behavioural tape transport answering the controller's commands
`timescale 1ns/1ns
module mtc_tape_model
  import mtc_pkg::*;
#(
  parameter logic [5:0] SD_DLY = 6'h08,
  parameter logic [5:0] SD_LEN = 6'h10
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire mtc_cmd_t tape_cmd,
  output mtc_status_t tape_status
);
  logic [7:0] pos_q;
  logic [5:0] run_q;
  logic [5:0] sd_q;
  logic chk_q;
  logic back;
  assign back = tape_cmd.rewind_cmd || tape_cmd.reverse_motion_cmd;
  // ==========================================================
  // Motion: a short block per set; rewinds hold until the marker
  always_ff @(posedge mclk) begin
    if (sys_rst || tape_cmd.set_pulse) begin
      run_q <= sys_rst ? 6'h00 : 6'h14;
    end else if (run_q != 6'h00) begin
      if (run_q > 6'h01 || !tape_cmd.rewind_cmd || pos_q == 8'h00) run_q <= run_q - 6'h01;
      if (tape_cmd.reverse_motion_cmd && pos_q == 8'h00 && run_q < 6'h10) run_q <= 6'h00;
    end
  end
  // Position kept apart so a rewind can outlast a block
  always_ff @(posedge mclk) begin
    if (sys_rst) pos_q <= 8'h00;
    else if (run_q != 6'h00 && tape_cmd.forward_motion_cmd) pos_q <= pos_q + 8'h01;
    else if (run_q != 6'h00 && back && pos_q != 8'h00) pos_q <= pos_q - 8'h01;
  end
  // Check strobes end a forward block; settling is shortened to keep runs brief
  always_ff @(posedge mclk) begin
    chk_q <= run_q == 6'h01 && tape_cmd.forward_motion_cmd;
    if (sys_rst) sd_q <= 6'h00;
    else if (run_q == 6'h01) sd_q <= 6'h01;
    else if (sd_q != 6'h00) sd_q <= sd_q + 6'h01;
  end
  // Always online, so every other line is valid
  assign tape_status = '{
    selected_online_status: 1'b1,
    transport_ready: run_q == 6'h00,
    tape_start_marker: pos_q == 8'h00,
    rewinding_status: run_q != 6'h00 && tape_cmd.rewind_cmd,
    settling_down_status: sd_q > SD_DLY && sd_q <= SD_DLY + SD_LEN,
    cyclic_check_strobe: chk_q,
    longitudinal_check_strobe: chk_q,
    vertical_parity_error: chk_q && !tape_cmd.write_enable_line,
    default: 1'b0
  };
endmodule // mtc_tape_model

//--- verification/testbench.sv
// Self-checking bench for the magtape controller core
`timescale 1ns/1ns
module testbench;
  import mtc_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, accumulator_input_gate, break_request;
  logic iot_strobe = 1'b0;
  logic proc_init = 1'b0;
  logic fourth_time_pulse = 1'b0;
  logic break_grant = 1'b0;
  logic [11:0] iot_code = 12'h0;
  logic [11:0] acc_bus = 12'h0;
  logic [11:0] mem_data = 12'h0;
  logic [11:0] address_counter;
  logic [2:0] unit_select = 3'h0;
  logic unit_change_flag, controller_busy, job_done_flag;
  mtc_status_t tape_status;
  mtc_cmd_t tape_cmd;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 32'h13C3;
  logic [31:0] exp_q[$];
  mtc_transport_control mtc_transport_control_inst (.mclk, .sys_rst, .clk_en, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .iot_strobe,
    .iot_code, .acc_bus, .accumulator_input_gate, .proc_init, .fourth_time_pulse,
    .break_request, .break_grant, .mem_data, .address_counter, .unit_select, .tape_status,
    .tape_cmd, .unit_change_flag, .controller_busy, .job_done_flag);
  mtc_tape_model mtc_tape_model_inst (.mclk, .sys_rst, .tape_cmd, .tape_status);
  // ==========================================================
  // Clock, time pulse four at random, read-answer monitor
  initial begin
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) fourth_time_pulse <= ($random(seed) & 3) == 0;
  always @(posedge mclk) begin
    if (avs_read && !avs_waitrequest) chk("readdata", avs_readdata, exp_q.pop_front());
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Avalon cycle; on a read d is the expected data
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    if (rd) exp_q.push_back(d);
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  // Strobe drops for a cycle so the next instruction sees a fresh rise
  task automatic iot(input logic [11:0] c, input logic [11:0] a);
    iot_code <= c;
    acc_bus <= a;
    iot_strobe <= 1'b1;
    @(posedge mclk);
    chk("gate", accumulator_input_gate, c[11:3] == IOT_GROUP);
    iot_strobe <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic grant(input logic wr, input logic cd);
    logic [11:0] m;
    int i;
    m = 12'($random(seed));
    for (i = 0; i < 50 && break_request !== 1'b1; i++) @(posedge mclk);
    chk("brk", break_request, 1);
    mem_data <= m;
    break_grant <= 1'b1;
    @(posedge mclk);
    break_grant <= 1'b0;
    repeat (2) @(posedge mclk);
    if (wr) chk("wdata", tape_cmd.write_data_bit, {m[7:2], m[1:0] & {2{!cd}}});
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    summarize();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [2:0] fns[8] = '{3'h4, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h1, 3'h0};
    logic [2:0] f;
    logic [11:0] r;
    logic cd;
    int i;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    bus(0, REG_STATUS, 32'hFFFF_FFFF);
    bus(0, 4'h2, 32'hFFFF_FFFF);
    bus(1, REG_STATUS, 32'h380);
    bus(1, 4'h2, 32'h0);
    r = 12'($random(seed));
    iot(IOT_LOAD_CA, r);
    chk("ca", address_counter, r);
    bus(1, REG_ADDR, {20'h0, r});
    iot(IOT_CLR_CA, r);
    chk("ca", address_counter, 0);
    iot(IOT_SET_BRK, 12'h0);
    grant(0, 0);
    chk("ca", address_counter, 1);
    // Every function code, data ones with a two-word count
    foreach (fns[k]) begin
      f = fns[k];
      // Go only fires while the unit is ready, so wait out the last block
      while (tape_status.transport_ready !== 1'b1) @(posedge mclk);
      cd = 1'($random(seed));
      iot(IOT_LOAD_WC, 12'hFFE);
      bus(0, REG_FUNC, {26'h0, 1'b1, 1'b0, cd, f});
      for (i = 0; i < 300 && tape_cmd.set_pulse !== 1'b1; i++) @(posedge mclk);
      chk("preset", i > 115 && i < 135, 1);
      repeat (2) @(posedge mclk);
      chk("cmd", tape_cmd[19:14], {f > 1 && f < 7, f == 7, f < 2, f == 5,
        f < 2 || f == 4 || f == 5, f == 4});
      chk("busy", controller_busy, 1);
      if (f inside {3'h2, 3'h3, 3'h4}) repeat (2) grant(f == 3'h4, cd);
      for (i = 0; i < 400 && job_done_flag !== 1'b1; i++) @(posedge mclk);
      @(posedge mclk);
      chk("busy", controller_busy, 0);
      chk("wdr", tape_cmd.write_data_ready, 0);
      iot(IOT_CLR_FLAGS, 12'h0);
      chk("done", job_done_flag, 0);
    end
    unit_select <= 3'h5;
    repeat (4) @(posedge mclk);
    chk("chg", unit_change_flag, 1);
    iot(IOT_LOAD_CA, 12'h5A5);
    iot(IOT_INIT, 12'h0);
    chk("ca", address_counter, 0);
    iot(IOT_LOAD_CA, 12'h5A5);
    iot(IOT_CLR_XPORT, 12'h0);
    chk("ca", address_counter, 0);
    // With the enable low a load instruction must leave no trace
    clk_en <= 1'b0;
    iot_code <= IOT_LOAD_CA;
    acc_bus <= 12'h3C3;
    iot_strobe <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("freeze", {accumulator_input_gate, address_counter}, 0);
    iot_strobe <= 1'b0;
    clk_en <= 1'b1;
    @(posedge mclk);
    proc_init <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("init", {tape_cmd.transport_init, tape_cmd.tape_init}, 3);
    proc_init <= 1'b0;
    repeat (3) @(posedge mclk);
    summarize();
  end
endmodule // testbench
